// >>> ifnc_regs.svh
// Register offsets, field positions and reset values of the IF front end
`ifndef IFNC_REGS_SVH
`define IFNC_REGS_SVH

`define IFNC_ADDR_CTRL        7'h01
`define IFNC_ADDR_ATT0        7'h03
`define IFNC_ADDR_DLY0        7'h04
`define IFNC_ADDR_FREQ_HI     7'h05
`define IFNC_ADDR_FREQ_LO     7'h06
`define IFNC_ADDR_PHASE_HI    7'h07
`define IFNC_ADDR_PHASE_LO    7'h08
`define IFNC_ADDR_DEC_RATE    7'h09
`define IFNC_ADDR_SCALE_SHIFT 7'h0a
`define IFNC_ADDR_FIR1        7'h0b
`define IFNC_ADDR_FIR2A       7'h0c
`define IFNC_ADDR_FIR2B       7'h0d
`define IFNC_ADDR_FIR_OPT     7'h0e
`define IFNC_ADDR_ATT1        7'h0f
`define IFNC_ADDR_DLY1        7'h10
`define IFNC_ADDR_LIMIT0      7'h2e
`define IFNC_ADDR_LIMIT1      7'h2f
`define IFNC_ADDR_STATUS      7'h30

`define IFNC_CTRL_CONV_EN0    0
`define IFNC_CTRL_CONV_EN1    1
`define IFNC_CTRL_GAIN0       2
`define IFNC_CTRL_GAIN1       3
`define IFNC_CTRL_CH0_EN      4
`define IFNC_CTRL_SYNC        6
`define IFNC_CTRL_MASK        16'h007f

`define IFNC_SCALE_MSB        11
`define IFNC_SCALE_LSB        6
`define IFNC_SHIFT_MSB        5
`define IFNC_SHIFT_LSB        0
`define IFNC_SCALE_FRAC_BITS  7'h05

`define IFNC_RATE_MIN         9'h004
`define IFNC_RATE_MAX         9'h100

`define IFNC_RST_DEC_RATE     9'h004
`define IFNC_RST_SCALE_SHIFT  12'h80a
`define IFNC_RST_LIMIT        12'hfff
`define IFNC_ATT_MAX_CODE     3'h6

`endif

// >>> ifnc_pkg.sv
// Types shared by the IF front end
package ifnc_pkg;

    // Attenuator delay sequencer, one-hot
    typedef enum logic [1:0] {
        ATT_IDLE = 2'b01,
        ATT_WAIT = 2'b10
    } ifnc_att_st_t;

    typedef logic [11:0] ifnc_sample_t;
    typedef logic [15:0] ifnc_word_t;
    typedef logic [6:0]  ifnc_addr_t;

endpackage

// >>> ifnc_front.sv
// IF converter control, event detection, attenuator, oscillator mixer and comb decimator
//
// Operation
// - Both enables set: both converters fully biased
// - One enable set: other converter minimum bias
// - No enables set: all converters minimum bias
// - Gain bit clear unity, set doubles gain
// - Full-scale overflow raises interrupt-capable event
// - Magnitude above 12-bit limit raises event
// - Status records type and channel, maskless
// - Attenuation 3 dB steps, code 6 18 dB
// - Attenuation write starts delay, applies at zero
// - Rewrite during delay discards pending, restarts
// - Channel runs only while enable bit set
// - 32-bit words split, upper half lower address
// - I is sample times cosine, Q sine
// - Frequency and phase scale by two-to-32
// - Sync high holds accumulator at phase word
// - Sync low adds frequency word every cycle while channel enabled
// - Fifth-order comb decimator, rate 4 to 256
// - Gain is rate^5 times scale/32 over 2^shift
`timescale 1ns/1ns
`include "ifnc_regs.svh"

module ifnc_front #(
    parameter int CW = 64,
    parameter int OW = 24
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_reset,
    input  wire logic                  i_reg_wr_en,
    input  wire logic                  i_reg_rd_en,
    input  wire ifnc_pkg::ifnc_addr_t  i_reg_addr,
    input  wire ifnc_pkg::ifnc_word_t  i_reg_wdata,
    output logic [15:0]                o_reg_rdata,
    input  wire ifnc_pkg::ifnc_sample_t i_conv0_sample,
    input  wire ifnc_pkg::ifnc_sample_t i_conv1_sample,
    output logic                       o_conv0_full_bias,
    output logic                       o_conv1_full_bias,
    output logic                       o_conv0_double_gain,
    output logic                       o_conv1_double_gain,
    output logic [3:0]                 o_conv_events,
    output logic [11:0]                o_conv1_scaled_sample,
    output logic [OW-1:0]              o_comb_i,
    output logic [OW-1:0]              o_comb_q,
    output logic                       o_comb_valid
);
    import ifnc_pkg::*;

    localparam int MW = 24;

    typedef struct packed {
        logic [15:0]               ctrl;
        logic [1:0][2:0]           att_wr;
        logic [1:0][2:0]           att_act;
        logic [1:0][15:0]          att_dly;
        logic [1:0][15:0]          att_cnt;
        ifnc_att_st_t [1:0]        att_st;
        logic [31:0]               freq;
        logic [31:0]               phase;
        logic [8:0]                dec;
        logic [11:0]               scs;
        logic [3:0][15:0]          fir;
        logic [1:0][11:0]          lim;
        logic [3:0]                status;
        logic [3:0]                ev;
        logic [31:0]               acc;
        logic [1:0][11:0]          smp;
        logic [1:0][MW-1:0]        mix;
        logic [1:0][4:0][CW-1:0]   integ;
        logic [1:0][4:0][CW-1:0]   combd;
        logic [8:0]                dcnt;
        logic [1:0][OW-1:0]        out;
        logic                      ovalid;
        logic [15:0]               rdata;
    } ifnc_state_t;

    ifnc_state_t st_r;
    ifnc_state_t st_nxt;

    // Q15 gain per 3 dB step; codes above 6 saturate at 18 dB
    function automatic logic [15:0] att_gain(input logic [2:0] code);
        case (code)
            3'h0:    att_gain = 16'h7fff;
            3'h1:    att_gain = 16'h5a9e;
            3'h2:    att_gain = 16'h4027;
            3'h3:    att_gain = 16'h2d6b;
            3'h4:    att_gain = 16'h2027;
            3'h5:    att_gain = 16'h16c3;
            default: att_gain = 16'h101d;
        endcase
    endfunction

    // Quarter-wave sine at half-step offsets, so the four quadrants mirror exactly
    function automatic logic [11:0] quarter_sine(input logic [3:0] idx);
        case (idx)
            4'h0:    quarter_sine = 12'h064;
            4'h1:    quarter_sine = 12'h12c;
            4'h2:    quarter_sine = 12'h1f1;
            4'h3:    quarter_sine = 12'h2b2;
            4'h4:    quarter_sine = 12'h36b;
            4'h5:    quarter_sine = 12'h41c;
            4'h6:    quarter_sine = 12'h4c3;
            4'h7:    quarter_sine = 12'h55f;
            4'h8:    quarter_sine = 12'h5ed;
            4'h9:    quarter_sine = 12'h66c;
            4'ha:    quarter_sine = 12'h6dc;
            4'hb:    quarter_sine = 12'h73b;
            4'hc:    quarter_sine = 12'h787;
            4'hd:    quarter_sine = 12'h7c2;
            4'he:    quarter_sine = 12'h7e9;
            default: quarter_sine = 12'h7fd;
        endcase
    endfunction

    // Full-cycle sine from the top six phase bits; one full turn is 2^32
    function automatic logic signed [11:0] sine64(input logic [5:0] p);
        logic [11:0] mag;
        mag = p[4] ? quarter_sine(~p[3:0]) : quarter_sine(p[3:0]);
        sine64 = p[5] ? -$signed(mag) : $signed(mag);
    endfunction

    // Rates outside 4..256 are clamped so the decimation counter never stalls
    function automatic logic [8:0] eff_rate(input logic [8:0] r);
        if (r < `IFNC_RATE_MIN) begin
            eff_rate = `IFNC_RATE_MIN;
        end else if (r > `IFNC_RATE_MAX) begin
            eff_rate = `IFNC_RATE_MAX;
        end else begin
            eff_rate = r;
        end
    endfunction

    // Next-state logic for the whole block
    always_comb begin
        logic [1:0]            att_hit;
        logic [3:0]            clr;
        logic [11:0]           raw;
        logic [12:0]           mag;
        logic signed [28:0]    ap;
        logic signed [CW-1:0]  cv;
        logic signed [CW-1:0]  df;
        logic signed [CW+6:0]  prod;
        logic [6:0]            sh;
        logic                  en;
        logic                  tick;
        att_hit = 2'b00;
        clr = 4'h0;
        raw = 12'h000;
        mag = 13'h0000;
        ap = '0;
        cv = '0;
        df = '0;
        prod = '0;
        sh = 7'h00;
        en = st_r.ctrl[`IFNC_CTRL_CH0_EN];
        tick = 1'b0;
        st_nxt = st_r;
        st_nxt.ev = 4'h0;
        st_nxt.ovalid = 1'b0;

        // Register writes; 32-bit words keep the upper half at the lower address
        if (i_reg_wr_en) begin
            case (i_reg_addr)
                `IFNC_ADDR_CTRL:        st_nxt.ctrl = i_reg_wdata & `IFNC_CTRL_MASK;
                `IFNC_ADDR_ATT0: begin
                    st_nxt.att_wr[0] = i_reg_wdata[2:0];
                    att_hit[0] = 1'b1;
                end
                `IFNC_ADDR_ATT1: begin
                    st_nxt.att_wr[1] = i_reg_wdata[2:0];
                    att_hit[1] = 1'b1;
                end
                `IFNC_ADDR_DLY0:        st_nxt.att_dly[0] = i_reg_wdata;
                `IFNC_ADDR_DLY1:        st_nxt.att_dly[1] = i_reg_wdata;
                `IFNC_ADDR_FREQ_HI:     st_nxt.freq[31:16] = i_reg_wdata;
                `IFNC_ADDR_FREQ_LO:     st_nxt.freq[15:0] = i_reg_wdata;
                `IFNC_ADDR_PHASE_HI:    st_nxt.phase[31:16] = i_reg_wdata;
                `IFNC_ADDR_PHASE_LO:    st_nxt.phase[15:0] = i_reg_wdata;
                `IFNC_ADDR_DEC_RATE:    st_nxt.dec = i_reg_wdata[8:0];
                `IFNC_ADDR_SCALE_SHIFT: st_nxt.scs = i_reg_wdata[11:0];
                `IFNC_ADDR_FIR1:        st_nxt.fir[0] = i_reg_wdata;
                `IFNC_ADDR_FIR2A:       st_nxt.fir[1] = i_reg_wdata;
                `IFNC_ADDR_FIR2B:       st_nxt.fir[2] = i_reg_wdata;
                `IFNC_ADDR_FIR_OPT:     st_nxt.fir[3] = i_reg_wdata;
                `IFNC_ADDR_LIMIT0:      st_nxt.lim[0] = i_reg_wdata[11:0];
                `IFNC_ADDR_LIMIT1:      st_nxt.lim[1] = i_reg_wdata[11:0];
                `IFNC_ADDR_STATUS:      clr = i_reg_wdata[3:0];
                default: begin
                end
            endcase
        end

        // Per converter: events, attenuator sequencer, scaled sample
        for (int c = 0; c < 2; c++) begin
            raw = (c == 0) ? i_conv0_sample : i_conv1_sample;
            // Either extreme code means the input ran past full scale
            st_nxt.ev[c] = (raw == 12'h7ff) || (raw == 12'h800);
            mag = raw[11] ? (13'h0000 - {1'b1, raw}) : {1'b0, raw};
            st_nxt.ev[2 + c] = mag > {1'b0, st_r.lim[c]};
            case (st_r.att_st[c])
                ATT_IDLE: begin
                end
                ATT_WAIT: begin
                    if (st_r.att_cnt[c] == 16'h0000) begin
                        st_nxt.att_act[c] = st_r.att_wr[c];
                        st_nxt.att_st[c] = ATT_IDLE;
                    end else begin
                        st_nxt.att_cnt[c] = st_r.att_cnt[c] - 16'h0001;
                    end
                end
                default: st_nxt.att_st[c] = ATT_IDLE;
            endcase
            // A fresh write overrides any pending value and restarts the count
            if (att_hit[c]) begin
                st_nxt.att_cnt[c] = st_nxt.att_dly[c];
                st_nxt.att_st[c] = ATT_WAIT;
            end
            ap = $signed(raw) * $signed({1'b0, att_gain(st_r.att_act[c])});
            st_nxt.smp[c] = ap[26:15];
        end

        // Sticky status: a new event wins over a clear in the same cycle
        st_nxt.status = (st_r.status & ~clr) | st_nxt.ev;

        // Phase accumulator; sync wins even while the channel is off
        if (st_r.ctrl[`IFNC_CTRL_SYNC]) begin
            st_nxt.acc = st_r.phase;
        end else if (en) begin
            st_nxt.acc = st_r.acc + st_r.freq;
        end

        if (en) begin
            // Mixer from the attenuated channel 0 sample
            st_nxt.mix[0] = MW'($signed(st_r.smp[0]) * sine64(st_r.acc[31:26] + 6'h10));
            st_nxt.mix[1] = MW'($signed(st_r.smp[0]) * sine64(st_r.acc[31:26]));
            tick = st_r.dcnt == 9'h000;
            st_nxt.dcnt = tick ? (eff_rate(st_r.dec) - 9'h001) : (st_r.dcnt - 9'h001);
            for (int c = 0; c < 2; c++) begin
                // Five integrators at the full rate, pipelined stage to stage
                st_nxt.integ[c][0] = st_r.integ[c][0]
                                   + CW'($signed(st_r.mix[c]));
                for (int k = 1; k < 5; k++) begin
                    st_nxt.integ[c][k] = st_r.integ[c][k] + st_r.integ[c][k-1];
                end
                // Five combs at the decimated rate, then scale and shift
                if (tick) begin
                    cv = $signed(st_r.integ[c][4]);
                    for (int k = 0; k < 5; k++) begin
                        df = cv - $signed(st_r.combd[c][k]);
                        st_nxt.combd[c][k] = cv;
                        cv = df;
                    end
                    prod = cv * $signed({1'b0, st_r.scs[`IFNC_SCALE_MSB:`IFNC_SCALE_LSB]});
                    sh = {1'b0, st_r.scs[`IFNC_SHIFT_MSB:`IFNC_SHIFT_LSB]}
                       + `IFNC_SCALE_FRAC_BITS;
                    // Low bits kept; wrap if software leaves gain above one
                    st_nxt.out[c] = OW'(prod >>> sh);
                end
            end
            st_nxt.ovalid = tick;
        end else begin
            // Channel off: mixer, integrators, combs and count held cleared
            st_nxt.mix = '0;
            st_nxt.integ = '0;
            st_nxt.combd = '0;
            st_nxt.dcnt = 9'h000;
        end

        // Registered read data, one cycle after the read strobe
        if (i_reg_rd_en) begin
            case (i_reg_addr)
                `IFNC_ADDR_CTRL:        st_nxt.rdata = st_r.ctrl;
                `IFNC_ADDR_ATT0:        st_nxt.rdata = {13'h0000, st_r.att_wr[0]};
                `IFNC_ADDR_ATT1:        st_nxt.rdata = {13'h0000, st_r.att_wr[1]};
                `IFNC_ADDR_DLY0:        st_nxt.rdata = st_r.att_dly[0];
                `IFNC_ADDR_DLY1:        st_nxt.rdata = st_r.att_dly[1];
                `IFNC_ADDR_FREQ_HI:     st_nxt.rdata = st_r.freq[31:16];
                `IFNC_ADDR_FREQ_LO:     st_nxt.rdata = st_r.freq[15:0];
                `IFNC_ADDR_PHASE_HI:    st_nxt.rdata = st_r.phase[31:16];
                `IFNC_ADDR_PHASE_LO:    st_nxt.rdata = st_r.phase[15:0];
                `IFNC_ADDR_DEC_RATE:    st_nxt.rdata = {7'h00, st_r.dec};
                `IFNC_ADDR_SCALE_SHIFT: st_nxt.rdata = {4'h0, st_r.scs};
                `IFNC_ADDR_FIR1:        st_nxt.rdata = st_r.fir[0];
                `IFNC_ADDR_FIR2A:       st_nxt.rdata = st_r.fir[1];
                `IFNC_ADDR_FIR2B:       st_nxt.rdata = st_r.fir[2];
                `IFNC_ADDR_FIR_OPT:     st_nxt.rdata = st_r.fir[3];
                `IFNC_ADDR_LIMIT0:      st_nxt.rdata = {4'h0, st_r.lim[0]};
                `IFNC_ADDR_LIMIT1:      st_nxt.rdata = {4'h0, st_r.lim[1]};
                `IFNC_ADDR_STATUS:      st_nxt.rdata = {12'h000, st_r.status};
                default:                st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_r <= '0;
            st_r.dec <= `IFNC_RST_DEC_RATE;
            st_r.scs <= `IFNC_RST_SCALE_SHIFT;
            st_r.lim <= {`IFNC_RST_LIMIT, `IFNC_RST_LIMIT};
            st_r.att_st <= {ATT_IDLE, ATT_IDLE};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Bias follows the enable bits directly; a cleared enable means minimum bias
    assign o_conv0_full_bias = st_r.ctrl[`IFNC_CTRL_CONV_EN0];
    assign o_conv1_full_bias = st_r.ctrl[`IFNC_CTRL_CONV_EN1];
    assign o_conv0_double_gain = st_r.ctrl[`IFNC_CTRL_GAIN0];
    assign o_conv1_double_gain = st_r.ctrl[`IFNC_CTRL_GAIN1];
    assign o_conv_events = st_r.ev;
    assign o_conv1_scaled_sample = st_r.smp[1];
    assign o_comb_i = st_r.out[0];
    assign o_comb_q = st_r.out[1];
    assign o_comb_valid = st_r.ovalid;
    assign o_reg_rdata = st_r.rdata;

endmodule

// >>> ifnc_tuner_model.sv
// Tuner IF output model driving both converter sample inputs
`timescale 1ns/1ns
module ifnc_tuner_model (
    input  wire logic                   i_clk_sys,
    input  wire ifnc_pkg::ifnc_sample_t i_level0,
    input  wire ifnc_pkg::ifnc_sample_t i_level1,
    output ifnc_pkg::ifnc_sample_t      o_conv0_sample,
    output ifnc_pkg::ifnc_sample_t      o_conv1_sample
);
    import ifnc_pkg::*;
    // Quiet IF until the bench asks for a level
    initial begin
        o_conv0_sample = '0;
        o_conv1_sample = '0;
    end
    // Levels land just after an edge, one clock late, as a real converter would
    always @(posedge i_clk_sys) begin
        o_conv0_sample <= i_level0;
        o_conv1_sample <= i_level1;
    end
endmodule

// >>> ifnc_front_chk.sv
// Port assertions for the IF front end, bound into its top module
`timescale 1ns/1ns
`include "ifnc_regs.svh"
module ifnc_front_chk (
    input wire logic                   i_clk_sys,
    input wire logic                   i_reset,
    input wire logic                   i_reg_wr_en,
    input wire logic                   i_reg_rd_en,
    input wire ifnc_pkg::ifnc_addr_t   i_reg_addr,
    input wire ifnc_pkg::ifnc_word_t   i_reg_wdata,
    input wire logic [15:0]            o_reg_rdata,
    input wire ifnc_pkg::ifnc_sample_t i_conv0_sample,
    input wire ifnc_pkg::ifnc_sample_t i_conv1_sample,
    input wire logic                   o_conv0_full_bias,
    input wire logic                   o_conv1_full_bias,
    input wire logic                   o_conv0_double_gain,
    input wire logic                   o_conv1_double_gain,
    input wire logic [3:0]             o_conv_events,
    input wire logic                   o_comb_valid
);
    import ifnc_pkg::*;
    logic [11:0] lim0_r;
    logic [8:0]  rate_r;
    logic        en_r;
    logic [12:0] mag0;
    logic        ovf0;
    // 13 bits so that the most negative code counts as 2048
    assign mag0 = i_conv0_sample[11] ? 13'h1000 - {1'b0, i_conv0_sample} : {1'b0, i_conv0_sample};
    assign ovf0 = i_conv0_sample == 12'h7ff || i_conv0_sample == 12'h800;
    // Shadow of the settings that the properties depend on
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            lim0_r <= 12'hfff;
            rate_r <= 9'h004;
            en_r   <= 1'b0;
        end else if (i_reg_wr_en) begin
            if (i_reg_addr == `IFNC_ADDR_LIMIT0) lim0_r <= i_reg_wdata[11:0];
            if (i_reg_addr == `IFNC_ADDR_DEC_RATE) rate_r <= i_reg_wdata[8:0];
            if (i_reg_addr == `IFNC_ADDR_CTRL) en_r <= i_reg_wdata[4];
        end
    end
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);
    sequence s_ctrl_wr;
        i_reg_wr_en && i_reg_addr == `IFNC_ADDR_CTRL;
    endsequence
    // Only the gap at rate 4 is checked; other rates would need a counter
    sequence s_gap4;
        (!o_comb_valid) [*3] ##1 (o_comb_valid || !en_r);
    endsequence
    a_bias_follow: assert property (s_ctrl_wr |=>
        {o_conv1_full_bias, o_conv0_full_bias} == $past(i_reg_wdata[1:0]))
        else $error("bias outputs differ from control write");
    a_gain_follow: assert property (s_ctrl_wr |=>
        {o_conv1_double_gain, o_conv0_double_gain} == $past(i_reg_wdata[3:2]))
        else $error("gain outputs differ from control write");
    a_ovf_zero: assert property (ovf0 |=> o_conv_events[0])
        else $error("converter zero overflow not flagged");
    a_ovf_one: assert property (##1 o_conv_events[1] ==
        $past(i_conv1_sample == 12'h7ff || i_conv1_sample == 12'h800))
        else $error("converter one overflow flag wrong");
    a_limit_zero: assert property (mag0 > {1'b0, lim0_r} |=> o_conv_events[2])
        else $error("converter zero limit event missing");
    a_limit_read: assert property (i_reg_rd_en && i_reg_addr == `IFNC_ADDR_LIMIT0 |=>
        o_reg_rdata == {4'h0, $past(lim0_r)})
        else $error("limit readback wrong");
    a_idle_quiet: assert property (!en_r |=> !o_comb_valid)
        else $error("sample emitted while channel idle");
    a_first_valid: assert property (s_ctrl_wr ##0 i_reg_wdata[4] && !en_r |=>
        ##1 o_comb_valid)
        else $error("first decimated sample not on time");
    a_dec_spacing: assert property (o_comb_valid && en_r && rate_r == 9'h004 |=> s_gap4)
        else $error("decimated samples not four cycles apart");
endmodule
bind ifnc_front ifnc_front_chk u_chk (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_reg_wr_en(i_reg_wr_en),
    .i_reg_rd_en(i_reg_rd_en), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_conv0_sample(i_conv0_sample),
    .i_conv1_sample(i_conv1_sample), .o_conv0_full_bias(o_conv0_full_bias),
    .o_conv1_full_bias(o_conv1_full_bias), .o_conv0_double_gain(o_conv0_double_gain),
    .o_conv1_double_gain(o_conv1_double_gain), .o_conv_events(o_conv_events),
    .o_comb_valid(o_comb_valid));

// >>> ifnc_front_tb.sv
// Self-checking bench for the IF front end with a tuner model at its inputs
`timescale 1ns/1ns
`include "ifnc_regs.svh"
module ifnc_front_tb;
    import ifnc_pkg::*;
    typedef struct {int r; int sc; int sh; int ph; int fr; real g;} ifnc_cic_case_t;
    logic         clk_sys = 1'b0;
    logic         rst = 1'b1;
    logic         wr_en = 1'b0;
    logic         rd_en = 1'b0;
    ifnc_addr_t   addr = '0;
    ifnc_word_t   wdata = '0;
    ifnc_sample_t lvl0 = '0;
    ifnc_sample_t lvl1 = '0;
    ifnc_sample_t smp0;
    ifnc_sample_t smp1;
    logic [15:0]  rdata;
    logic [15:0]  rv;
    logic [1:0]   bias;
    logic [1:0]   gain;
    logic [3:0]   events;
    logic [11:0]  scaled;
    logic [23:0]  comb_i;
    logic [23:0]  comb_q;
    logic         comb_valid;
    logic [11:0]  la;
    logic [11:0]  lb;
    int           failures = 0;
    int           n_checks = 0;
    integer       seed = 32'h387a1a0b;
    int           gtab[7] = '{16'h7fff, 16'h5a9e, 16'h4027, 16'h2d6b, 16'h2027, 16'h16c3, 16'h101d};
    ifnc_addr_t   rst_a[5] = '{7'h01, 7'h09, 7'h0a, 7'h2e, 7'h02};
    ifnc_word_t   rst_v[5] = '{16'h0000, 16'h0004, 16'h080a, 16'h0fff, 16'h0000};
    // Scale and shift picked by software for unity gain except where noted
    ifnc_cic_case_t cases[6] = '{'{4, 32, 10, 0, 0, 1.0}, '{4, 32, 10, 32'h8000, 0, 1.0},
        '{4, 16, 10, 32'h4000, 0, 0.5}, '{4, 32, 9, 0, 0, 2.0},
        '{128, 32, 35, 32'hc000, 0, 1.0}, '{4, 32, 10, 0, 32'h8000, 0.0}};

    always #5 clk_sys = ~clk_sys;

    ifnc_tuner_model tuner (.i_clk_sys(clk_sys), .i_level0(lvl0), .i_level1(lvl1),
        .o_conv0_sample(smp0), .o_conv1_sample(smp1));
    ifnc_front uut (.i_clk_sys(clk_sys), .i_reset(rst), .i_reg_wr_en(wr_en),
        .i_reg_rd_en(rd_en), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_conv0_sample(smp0), .i_conv1_sample(smp1), .o_conv0_full_bias(bias[0]),
        .o_conv1_full_bias(bias[1]), .o_conv0_double_gain(gain[0]),
        .o_conv1_double_gain(gain[1]), .o_conv_events(events),
        .o_conv1_scaled_sample(scaled), .o_comb_i(comb_i), .o_comb_q(comb_q),
        .o_comb_valid(comb_valid));

    // Comparison, verdict and register access helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input ifnc_addr_t a, input ifnc_word_t d);
        @(posedge clk_sys);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input ifnc_addr_t a, output logic [15:0] d);
        @(posedge clk_sys);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    function automatic logic [12:0] mag(logic [11:0] s);
        return s[11] ? 13'h1000 - {1'b0, s} : {1'b0, s};
    endfunction
    function automatic logic over(logic [11:0] s);
        return s == 12'h7ff || s == 12'h800;
    endfunction
    // Gain codes above six saturate at the deepest step
    function automatic logic [11:0] att_exp(logic [11:0] s, int c);
        int p;
        p = $signed(s) * gtab[c > 6 ? 6 : c];
        return p[26:15];
    endfunction
    function automatic logic near(logic [23:0] v, real e, real tol);
        return !$isunknown(v) && $signed(v) - e <= tol && e - $signed(v) <= tol;
    endfunction
    task automatic cic_case(input ifnc_cic_case_t t);
        real s;
        real ph;
        real tol;
        int  n;
        @(posedge clk_sys);
        lvl0 <= 12'($random(seed) % 900);
        wr(`IFNC_ADDR_CTRL, 16'h0043);
        wr(`IFNC_ADDR_DEC_RATE, 16'(t.r));
        wr(`IFNC_ADDR_SCALE_SHIFT, 16'(t.sc * 64 + t.sh));
        wr(`IFNC_ADDR_PHASE_HI, 16'(t.ph));
        wr(`IFNC_ADDR_PHASE_LO, 16'h1234);
        wr(`IFNC_ADDR_FREQ_HI, 16'(t.fr));
        wr(`IFNC_ADDR_FREQ_LO, 16'h0000);
        wr(`IFNC_ADDR_CTRL, t.fr == 0 ? 16'h0053 : 16'h0013);
        n = 0;
        for (int w = 0; w < 4000 && n < 12; w++) begin
            @(posedge clk_sys);
            #1 n += int'(comb_valid);
        end
        if (n < 12) begin
            check(32'(n), 32'd12);
            conclude();
        end
        // Mixer sees the channel zero sample after its 0 dB attenuator; sine peak is 2047
        s = 2047.0 * $signed(att_exp(lvl0, 0));
        ph = 6.283185307 * ((t.ph >> 10) + 0.5) / 64.0;
        tol = (s < 0 ? -s : s) * (t.g + 0.01) / 2047.0 + 8.0;
        check(near(comb_i, s * $cos(ph) * t.g, tol), 1);
        check(near(comb_q, s * $sin(ph) * t.g, tol), 1);
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            rd(rst_a[k], rv);
            check(rv, rst_v[k]);
        end
        $display("reset values done");
        for (int k = 0; k < 16; k++) begin
            wr(`IFNC_ADDR_CTRL, 16'(k));
            @(posedge clk_sys);
            #1 check(bias, k[1:0]);
            check(gain, k[3:2]);
        end
        wr(`IFNC_ADDR_CTRL, 16'hffff);
        rd(`IFNC_ADDR_CTRL, rv);
        check(rv, 16'h007f);
        $display("converter control done");
        for (int k = 0; k < 24; k++) begin
            la = 12'($random(seed));
            lb = 12'($random(seed) & 32'h3ff);
            wr(`IFNC_ADDR_LIMIT0, {4'h0, la});
            wr(`IFNC_ADDR_LIMIT1, {4'h0, lb});
            @(posedge clk_sys);
            lvl0 <= (k == 0) ? 12'h7ff : (k == 1) ? 12'h800 : (k == 2) ? la : 12'($random(seed));
            lvl1 <= (k == 3) ? 12'h800 : 12'($random(seed));
            repeat (2) @(posedge clk_sys);
            #1 check(events, {mag(lvl1) > {1'b0, lb}, mag(lvl0) > {1'b0, la},
                over(lvl1), over(lvl0)});
        end
        // Status must hold an event that was signalled for only one cycle
        lvl0 <= 12'h000;
        lvl1 <= 12'h000;
        wr(`IFNC_ADDR_LIMIT0, 16'h0fff);
        wr(`IFNC_ADDR_STATUS, 16'h000f);
        @(posedge clk_sys);
        lvl0 <= 12'h800;
        @(posedge clk_sys);
        lvl0 <= 12'h000;
        repeat (3) @(posedge clk_sys);
        rd(`IFNC_ADDR_STATUS, rv);
        check(rv, 16'h0001);
        wr(`IFNC_ADDR_STATUS, 16'h0001);
        rd(`IFNC_ADDR_STATUS, rv);
        check(rv, 16'h0000);
        $display("events done");
        @(posedge clk_sys);
        lvl1 <= 12'($random(seed));
        wr(`IFNC_ADDR_DLY1, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            wr(`IFNC_ADDR_ATT1, 16'(c));
            repeat (3) @(posedge clk_sys);
            #1 check(scaled, att_exp(lvl1, c));
        end
        // A rewrite inside the delay must drop the pending code
        wr(`IFNC_ADDR_DLY1, 16'h0005);
        wr(`IFNC_ADDR_ATT1, 16'h0002);
        repeat (2) @(posedge clk_sys);
        wr(`IFNC_ADDR_ATT1, 16'h0004);
        repeat (3) @(posedge clk_sys);
        #1 check(scaled, att_exp(lvl1, 7));
        repeat (3) @(posedge clk_sys);
        #1 check(scaled, att_exp(lvl1, 7));
        @(posedge clk_sys);
        #1 check(scaled, att_exp(lvl1, 4));
        rd(`IFNC_ADDR_ATT1, rv);
        check(rv, 16'h0004);
        $display("attenuator done");
        foreach (cases[k]) cic_case(cases[k]);
        wr(`IFNC_ADDR_CTRL, 16'h0003);
        repeat (2) @(posedge clk_sys);
        la = '0;
        for (int w = 0; w < 40; w++) begin
            @(posedge clk_sys);
            #1 la = la + 12'(comb_valid);
        end
        check(la, 12'h000);
        $display("mixer and decimator done");
        conclude();
    end
endmodule
